// ---- verilog/twdrs_map.vh ----
// Constants of the two-wire debug register-select port.
// Included by the read-mux and port design files; holds definitions only.
`ifndef TWDRS_MAP_VH
`define TWDRS_MAP_VH

// Target codes written to the address register.
`define TWDRS_CODE_PART_ID   8'h00
`define TWDRS_CODE_REV_ID    8'h01
`define TWDRS_CODE_HALT      8'h02
`define TWDRS_CODE_PROG_EN   8'hdf
`define TWDRS_CODE_PROG_DATA 8'hbf
`define TWDRS_CODE_PROG_STAT 8'hb7
`define TWDRS_CODE_ADDR_HI   8'haf
`define TWDRS_CODE_ADDR_LO   8'hae
`define TWDRS_CODE_CHK0      8'ha9
`define TWDRS_CODE_CHK1      8'haa
`define TWDRS_CODE_CHK2      8'hab
`define TWDRS_CODE_CHK3      8'hac

// Internal select indices produced by the target decoder.
`define TWDRS_IDX_PART_ID   4'h0
`define TWDRS_IDX_REV_ID    4'h1
`define TWDRS_IDX_HALT      4'h2
`define TWDRS_IDX_PROG_EN   4'h3
`define TWDRS_IDX_PROG_DATA 4'h4
`define TWDRS_IDX_PROG_STAT 4'h5
`define TWDRS_IDX_ADDR_HI   4'h6
`define TWDRS_IDX_ADDR_LO   4'h7
`define TWDRS_IDX_CHK0      4'h8
`define TWDRS_IDX_NONE      4'hf

// Reset values.
`define TWDRS_RST_TARGET    8'h00
`define TWDRS_RST_BYTE      8'h00

// Field positions.
`define TWDRS_STAT_BUSY_BIT 7
`define TWDRS_PSTAT_WLK_BIT 7
`define TWDRS_PSTAT_RLK_BIT 6
`define TWDRS_PSTAT_ERR_BIT 0
`define TWDRS_INS_WR_BIT    0
`define TWDRS_INS_ADDR_BIT  1

// Timing: link clock held low this long abandons any frame.
`define TWDRS_CLK_KHZ       20000
`define TWDRS_LINK_RST_NS   20000
`define TWDRS_LINK_RST_CYC  ((`TWDRS_LINK_RST_NS * `TWDRS_CLK_KHZ) / 1000000)

`endif

// ---- verilog/twdrs_sync.v ----
// Two-flop synchroniser for pin inputs of the debug port.
// Assumes the inputs are asynchronous to ref_clk; stage one feeds only stage two.
`timescale 1ns/100ps
module twdrs_sync #(
  parameter W = 2
) (
  input  wire         ref_clk,
  input  wire         nrst,
  input  wire [W-1:0] async_in,
  output reg  [W-1:0] sync_out
);

  reg [W-1:0] meta_r;

  // Both stages clear on reset; the output then follows the pins two edges late.
  always @(posedge ref_clk) begin
    if (!nrst) begin
      meta_r   <= {W{1'b0}};
      sync_out <= {W{1'b0}};
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule // twdrs_sync

// ---- verilog/twdrs_rd_mux.v ----
// Registered read-back selector of the debug port data registers.
// Assumes the select index is already decoded by the parent and stable while read.
`timescale 1ns/100ps
`include "twdrs_map.vh"
module twdrs_rd_mux (
  input  wire        ref_clk,
  input  wire        nrst,
  input  wire [3:0]  sel_idx,
  input  wire        status_rd,
  input  wire [7:0]  status_byte,
  input  wire [7:0]  part_id,
  input  wire [7:0]  rev_id,
  input  wire [7:0]  halt_byte,
  input  wire [7:0]  prog_en_byte,
  input  wire [7:0]  prog_data_byte,
  input  wire [7:0]  prog_stat_byte,
  input  wire [15:0] prog_addr,
  input  wire [31:0] checksum,
  output reg  [7:0]  rd_byte
);

  reg  [7:0] pick;
  wire [1:0] chk_sel;

  assign chk_sel = sel_idx[1:0];

  // Selects the byte the link would shift out; unknown codes read as zero.
  always @* begin
    pick = `TWDRS_RST_BYTE;
    if (status_rd) begin
      pick = status_byte;
    end else begin
      case (sel_idx)
        `TWDRS_IDX_PART_ID:   pick = part_id;
        `TWDRS_IDX_REV_ID:    pick = rev_id;
        `TWDRS_IDX_HALT:      pick = halt_byte;
        `TWDRS_IDX_PROG_EN:   pick = prog_en_byte;
        `TWDRS_IDX_PROG_DATA: pick = prog_data_byte;
        `TWDRS_IDX_PROG_STAT: pick = prog_stat_byte;
        `TWDRS_IDX_ADDR_HI:   pick = prog_addr[15:8];
        `TWDRS_IDX_ADDR_LO:   pick = prog_addr[7:0];
        default: begin
          if (sel_idx[3] && !sel_idx[2]) begin
            pick = checksum[chk_sel*8 +: 8];
          end
        end
      endcase
    end
  end

  // The chosen byte leaves through a register.
  always @(posedge ref_clk) begin
    if (!nrst) begin
      rd_byte <= `TWDRS_RST_BYTE;
    end else begin
      rd_byte <= pick;
    end
  end

endmodule // twdrs_rd_mux

// ---- verilog/twdrs_port.v ----
// Top of the two-wire debug register-select port.
// Assumes a 20 MHz ref_clk, a memory controller on the same clock, and an
// external tool that clocks the link far slower than ref_clk.
//
// What this block does
// (RL1) Two pins only: tool drives the clock; data pin is driven by either side.
// (RL2) Address write stores a target code steering later data reads and writes.
// (RL3) Code 0x00 reaches the read-only part identifier; writes are ignored.
// (RL4) Code 0x01 reaches the read-only silicon revision; writes are ignored.
// (RL5) Code 0x02 reaches the core halt control register.
// (RL6) Code 0xDF reaches the programming enable register.
// (RL7) Code 0xBF reaches the programming data register carrying memory bytes.
// (RL8) Code 0xB7 reaches the programming status register.
// (RL9) Codes 0xAF and 0xAE reach upper and lower programming address bytes.
// (RL10) Codes 0xA9 to 0xAC reach checksum bytes zero to three in order.
// (RL11) Address read returns status; bit seven set while an operation runs.
// (RL12) These registers are reachable only over the two-wire link.
// (RL13) Status top bit shows write lock, next bit read lock, at the address.
// (RL14) Status bit zero set when the last memory access was refused.
// (RL15) Target code resets to zero so early accesses reach the part identifier.
// (RL16) Unknown target codes change nothing and read back a harmless value.
`timescale 1ns/100ps
`include "twdrs_map.vh"
module twdrs_port #(
  parameter [7:0] PART_ID = 8'h5a,  // Arbitrary value.
  parameter [7:0] REV_ID  = 8'h01   // Arbitrary value.
) (
  input  wire        ref_clk,
  input  wire        nrst,
  input  wire        link_clock_pin,
  input  wire        link_data_in,
  output reg         link_data_out,
  output reg         link_data_oe,
  input  wire        prog_done,
  input  wire        prog_refused,
  input  wire [7:0]  prog_rdata,
  input  wire        write_locked_in,
  input  wire        read_locked_in,
  input  wire [31:0] checksum_in,
  output reg  [7:0]  core_halt_ctrl,
  output reg  [7:0]  prog_enable_ctrl,
  output reg  [15:0] prog_addr,
  output reg  [7:0]  prog_wdata,
  output reg         prog_wr_req,
  output reg         prog_rd_req
);

  localparam [1:0] ST_IDLE = 2'd0;
  localparam [1:0] ST_INS  = 2'd1;
  localparam [1:0] ST_WDAT = 2'd2;
  localparam [1:0] ST_RDAT = 2'd3;
  localparam [31:0] LOW_MAX_W = `TWDRS_LINK_RST_CYC;
  localparam [8:0]  LOW_MAX   = LOW_MAX_W[8:0];

  reg  [1:0] state_r;
  reg  [2:0] bitcnt_r;
  reg  [1:0] ins_r;
  reg  [7:0] shift_r;
  reg        first_r;
  reg        clk_d_r;
  reg  [8:0] low_cnt_r;
  reg        wr_go_r;
  reg        rd_go_r;
  reg  [7:0] target_r;
  reg        busy_r;
  reg        op_rd_r;
  reg        err_r;
  reg        wlk_r;
  reg        rlk_r;
  wire [1:0] pins_s;
  wire       clk_s;
  wire       dat_s;
  wire       rise;
  wire       fall;
  wire       link_tmo;
  wire [3:0] sel_idx;
  wire [7:0] status_byte;
  wire [7:0] pstat_byte;
  wire [7:0] rd_byte;
  wire       is_addr;

  // Maps a stored target code onto an internal register index.
  function [3:0] twdrs_decode;
    input [7:0] code;
    begin
      case (code)
        `TWDRS_CODE_PART_ID:   twdrs_decode = `TWDRS_IDX_PART_ID;   // RL3
        `TWDRS_CODE_REV_ID:    twdrs_decode = `TWDRS_IDX_REV_ID;    // RL4
        `TWDRS_CODE_HALT:      twdrs_decode = `TWDRS_IDX_HALT;      // RL5
        `TWDRS_CODE_PROG_EN:   twdrs_decode = `TWDRS_IDX_PROG_EN;   // RL6
        `TWDRS_CODE_PROG_DATA: twdrs_decode = `TWDRS_IDX_PROG_DATA; // RL7
        `TWDRS_CODE_PROG_STAT: twdrs_decode = `TWDRS_IDX_PROG_STAT; // RL8
        `TWDRS_CODE_ADDR_HI:   twdrs_decode = `TWDRS_IDX_ADDR_HI;   // RL9
        `TWDRS_CODE_ADDR_LO:   twdrs_decode = `TWDRS_IDX_ADDR_LO;   // RL9
        `TWDRS_CODE_CHK0:      twdrs_decode = `TWDRS_IDX_CHK0;      // RL10
        `TWDRS_CODE_CHK1:      twdrs_decode = `TWDRS_IDX_CHK0 + 4'h1; // RL10
        `TWDRS_CODE_CHK2:      twdrs_decode = `TWDRS_IDX_CHK0 + 4'h2; // RL10
        `TWDRS_CODE_CHK3:      twdrs_decode = `TWDRS_IDX_CHK0 + 4'h3; // RL10
        default:               twdrs_decode = `TWDRS_IDX_NONE;      // RL16
      endcase
    end
  endfunction

  // Both link pins are resynchronised before anything looks at them.
  twdrs_sync #(
    .W (2)
  ) u_sync (
    .ref_clk  (ref_clk),
    .nrst     (nrst),
    .async_in ({link_clock_pin, link_data_in}),
    .sync_out (pins_s)
  );

  assign clk_s    = pins_s[1];
  assign dat_s    = pins_s[0];
  assign rise     = clk_s & ~clk_d_r;
  assign fall     = ~clk_s & clk_d_r;
  assign link_tmo = (low_cnt_r == LOW_MAX);
  assign sel_idx  = twdrs_decode(target_r);
  assign is_addr  = ins_r[`TWDRS_INS_ADDR_BIT];

  // Status byte of an address read: only the busy flag is defined.
  assign status_byte = {busy_r, 7'h00}; // RL11

  // Programming status: lock flags on top, refusal in bit zero.
  assign pstat_byte = {wlk_r, rlk_r, 5'h00, err_r}; // RL13 RL14

  // Read-back byte for the next read frame.
  twdrs_rd_mux u_rd_mux (
    .ref_clk        (ref_clk),
    .nrst           (nrst),
    .sel_idx        (sel_idx),
    .status_rd      (is_addr),
    .status_byte    (status_byte),
    .part_id        (PART_ID),
    .rev_id         (REV_ID),
    .halt_byte      (core_halt_ctrl),
    .prog_en_byte   (prog_enable_ctrl),
    .prog_data_byte (prog_wdata),
    .prog_stat_byte (pstat_byte),
    .prog_addr      (prog_addr),
    .checksum       (checksum_in),
    .rd_byte        (rd_byte)
  );

  // Edge history of the link clock and the idle-low watchdog.
  always @(posedge ref_clk) begin
    if (!nrst) begin
      clk_d_r   <= 1'b0;
      low_cnt_r <= 9'h000;
    end else begin
      clk_d_r <= clk_s;
      if (clk_s) begin
        low_cnt_r <= 9'h000;
      end else if (!link_tmo) begin
        low_cnt_r <= low_cnt_r + 9'h001;
      end
    end
  end

  // Frame sequencer: start bit, two instruction bits, then eight data bits
  // shifted in by the tool or out by this end, least significant bit first.
  always @(posedge ref_clk) begin
    if (!nrst) begin
      state_r       <= ST_IDLE;
      bitcnt_r      <= 3'h0;
      ins_r         <= 2'h0;
      shift_r       <= `TWDRS_RST_BYTE;
      first_r       <= 1'b0;
      wr_go_r       <= 1'b0;
      rd_go_r       <= 1'b0;
      link_data_out <= 1'b0;
      link_data_oe  <= 1'b0;
    end else begin
      wr_go_r <= 1'b0;
      rd_go_r <= 1'b0;
      if (link_tmo) begin
        state_r      <= ST_IDLE;
        link_data_oe <= 1'b0; // RL1
      end else begin
        case (state_r)
          ST_IDLE: begin
            if (rise && !dat_s) begin
              state_r  <= ST_INS;
              bitcnt_r <= 3'h0;
            end
          end
          ST_INS: begin
            if (rise) begin
              if (bitcnt_r == 3'h0) begin
                ins_r[0] <= dat_s;
                bitcnt_r <= 3'h1;
              end else begin
                ins_r[1] <= dat_s;
                bitcnt_r <= 3'h0;
                first_r  <= 1'b1;
                state_r  <= ins_r[`TWDRS_INS_WR_BIT] ? ST_WDAT : ST_RDAT;
              end
            end
          end
          ST_WDAT: begin
            if (rise) begin
              shift_r  <= {dat_s, shift_r[7:1]};
              bitcnt_r <= bitcnt_r + 3'h1;
              if (bitcnt_r == 3'h7) begin
                wr_go_r <= 1'b1;
                state_r <= ST_IDLE;
              end
            end
          end
          ST_RDAT: begin
            // This end drives after each falling edge; the tool samples on rising.
            if (fall) begin
              link_data_oe <= 1'b1; // RL1
              first_r      <= 1'b0;
              if (first_r) begin
                link_data_out <= rd_byte[0];
                shift_r       <= {1'b0, rd_byte[7:1]};
              end else begin
                link_data_out <= shift_r[0];
                shift_r       <= {1'b0, shift_r[7:1]};
              end
            end else if (rise && !first_r) begin
              bitcnt_r <= bitcnt_r + 3'h1;
              if (bitcnt_r == 3'h7) begin
                link_data_oe <= 1'b0; // RL1
                rd_go_r      <= 1'b1;
                state_r      <= ST_IDLE;
              end
            end
          end
          default: begin
            state_r <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // Address register and writable data registers, written from the link only.
  always @(posedge ref_clk) begin
    if (!nrst) begin
      target_r         <= `TWDRS_RST_TARGET; // RL15
      core_halt_ctrl   <= `TWDRS_RST_BYTE;
      prog_enable_ctrl <= `TWDRS_RST_BYTE;
      prog_addr        <= {`TWDRS_RST_BYTE, `TWDRS_RST_BYTE};
    end else if (wr_go_r) begin // RL12
      if (is_addr) begin
        target_r <= shift_r; // RL2
      end else begin
        case (sel_idx) // RL2
          `TWDRS_IDX_HALT:    core_halt_ctrl   <= shift_r; // RL5
          `TWDRS_IDX_PROG_EN: prog_enable_ctrl <= shift_r; // RL6
          `TWDRS_IDX_ADDR_HI: prog_addr[15:8]  <= shift_r; // RL9
          `TWDRS_IDX_ADDR_LO: prog_addr[7:0]   <= shift_r; // RL9
          default: begin
            // Identifier, revision, status, checksum and unknown codes hold.
            target_r <= target_r; // RL3 RL4 RL16
          end
        endcase
      end
    end
  end

  // Memory operations: a data write to the data register launches a write,
  // a data read of it launches a read whose result is the next byte read.
  always @(posedge ref_clk) begin
    if (!nrst) begin
      prog_wdata  <= `TWDRS_RST_BYTE;
      prog_wr_req <= 1'b0;
      prog_rd_req <= 1'b0;
      busy_r      <= 1'b0;
      op_rd_r     <= 1'b0;
      err_r       <= 1'b0;
    end else begin
      prog_wr_req <= 1'b0;
      prog_rd_req <= 1'b0;
      if (wr_go_r && !is_addr && sel_idx == `TWDRS_IDX_PROG_DATA && !busy_r) begin
        prog_wdata  <= shift_r; // RL7
        prog_wr_req <= 1'b1;
        busy_r      <= 1'b1;    // RL11
        op_rd_r     <= 1'b0;
      end else if (rd_go_r && !is_addr && sel_idx == `TWDRS_IDX_PROG_DATA && !busy_r) begin
        prog_rd_req <= 1'b1;    // RL7
        busy_r      <= 1'b1;    // RL11
        op_rd_r     <= 1'b1;
      end else if (busy_r && prog_done) begin
        busy_r <= 1'b0;         // RL11
        err_r  <= prog_refused; // RL14
        if (op_rd_r && !prog_refused) begin
          prog_wdata <= prog_rdata;
        end
      end
    end
  end

  // Lock flags follow the controller's view of the current address.
  always @(posedge ref_clk) begin
    if (!nrst) begin
      wlk_r <= 1'b0;
      rlk_r <= 1'b0;
    end else begin
      wlk_r <= write_locked_in; // RL13
      rlk_r <= read_locked_in;  // RL13
    end
  end

endmodule // twdrs_port

// ---- sim/twdrs_port_asserts.sv ----
// Checker of the register-select port, bound to its top module.
// Assumes ref_clk is the only clock and nrst the synchronous active-low reset.
`timescale 1ns/100ps
module twdrs_port_asserts (
  input logic        ref_clk,
  input logic        nrst,
  input logic        link_clock_pin,
  input logic        link_data_oe,
  input logic        prog_done,
  input logic [7:0]  core_halt_ctrl,
  input logic [7:0]  prog_enable_ctrl,
  input logic [15:0] prog_addr,
  input logic [7:0]  prog_wdata,
  input logic        prog_wr_req,
  input logic        prog_rd_req
);
  logic       busy_r;
  logic [9:0] low_cnt_r;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // Tracks one memory operation from its request to its completion.
  always @(posedge ref_clk) begin
    if (!nrst) busy_r <= 1'b0;
    else if (prog_wr_req || prog_rd_req) busy_r <= 1'b1;
    else if (prog_done) busy_r <= 1'b0;
  end
  // Counts cycles of low link clock, saturating so it never wraps.
  always @(posedge ref_clk) begin
    if (!nrst || link_clock_pin) low_cnt_r <= 10'h0;
    else if (low_cnt_r != 10'h3ff) low_cnt_r <= low_cnt_r + 10'h1;
  end
  reset_outs_a: assert property (@(posedge ref_clk) disable iff (1'b0) !nrst |=>
    (core_halt_ctrl == 8'h00 && prog_enable_ctrl == 8'h00 && prog_addr == 16'h0000
     && !prog_wr_req && !prog_rd_req && !link_data_oe)) else $error("outputs not cleared");
  wr_pulse_a: assert property (prog_wr_req |=> !prog_wr_req) else $error("long write");
  rd_pulse_a: assert property (prog_rd_req |=> !prog_rd_req) else $error("long read");
  req_excl_a: assert property (!(prog_wr_req && prog_rd_req)) else $error("both requests");
  busy_block_a: assert property (busy_r |-> !prog_wr_req && !prog_rd_req)
    else $error("request while busy");
  wdata_hold_a: assert property (prog_wr_req |=> $stable(prog_wdata)[*8])
    else $error("write data moved");
  oe_min_a: assert property ($rose(link_data_oe) |-> link_data_oe[*8])
    else $error("short drive");
  rd_after_a: assert property (prog_rd_req |-> link_data_oe || $past(link_data_oe)
    || $past(link_data_oe, 2)) else $error("read without read frame");
  link_abort_a: assert property (low_cnt_r >= 10'd410 |-> !link_data_oe)
    else $error("no abort on idle clock");
endmodule // twdrs_port_asserts

bind twdrs_port twdrs_port_asserts i_twdrs_port_asserts (
  .ref_clk(ref_clk), .nrst(nrst), .link_clock_pin(link_clock_pin),
  .link_data_oe(link_data_oe), .prog_done(prog_done), .core_halt_ctrl(core_halt_ctrl),
  .prog_enable_ctrl(prog_enable_ctrl), .prog_addr(prog_addr), .prog_wdata(prog_wdata),
  .prog_wr_req(prog_wr_req), .prog_rd_req(prog_rd_req));

// ---- sim/twdrs_tool.sv ----
// Behavioural debug tool: makes the link clock and shares the data pin.
// Assumes the device output enable is high only while the device drives.
`timescale 1ns/100ps
module twdrs_tool (
  input  wire  ref_clk,
  input  wire  link_data_out,
  input  wire  link_data_oe,
  output logic link_clock_pin,
  output wire  link_data_in
);
  logic drv_r;
  logic bit_r;
  // Wire level: device when enabled, else the tool, else the inverse of its last bit.
  assign link_data_in = link_data_oe ? link_data_out : (drv_r ? bit_r : ~bit_r);
  // The clock starts low long enough to run out the abort timer, then idles high.
  initial begin
    link_clock_pin = 1'b0;
    drv_r = 1'b0;
    bit_r = 1'b0;
    #30007 link_clock_pin = 1'b1;
  end
  // One bit: data changes with the fall and holds across the rise.
  task automatic send_bit(input logic b);
    link_clock_pin = 1'b0;
    drv_r = 1'b1;
    bit_r = b;
    #200 link_clock_pin = 1'b1;
    #200;
  endtask
  // Frame head: start bit, direction, register kind.
  task automatic head(input logic wr, input logic adr);
    wait (link_clock_pin === 1'b1);
    @(posedge ref_clk);
    #7;
    send_bit(1'b0);
    send_bit(wr);
    send_bit(adr);
  endtask
  task automatic write(input logic adr, input logic [7:0] d);
    head(1'b1, adr);
    for (int i = 0; i < 8; i++) send_bit(d[i]);
  endtask
  // The pin is released at each fall; a bit is taken just after the rise, because the
  // device lets go of the pin soon after the last rise.
  task automatic read(input logic adr, output logic [7:0] d);
    head(1'b0, adr);
    for (int i = 0; i < 8; i++) begin
      link_clock_pin = 1'b0;
      drv_r = 1'b0;
      #200 link_clock_pin = 1'b1;
      #10 d[i] = link_data_in;
      #190;
    end
  endtask
  // A data read stopped after its first fall; the clock then rests low.
  task automatic cut_low();
    head(1'b0, 1'b0);
    link_clock_pin = 1'b0;
    drv_r = 1'b0;
    #400;
  endtask
  // The clock returns to its idle high level with the data line high.
  task automatic cut_end();
    link_clock_pin = 1'b1;
    #200;
  endtask
endmodule // twdrs_tool

// ---- sim/tb_twdrs_port.sv ----
// Testbench of the register-select port with the tool model on the link.
// Assumes the design files are compiled first with verilog/ on the include path.
`timescale 1ns/100ps
module tb_twdrs_port;
  localparam [7:0] PID = 8'h5a;
  localparam [7:0] RID = 8'h01;
  logic        ref_clk, nrst, prog_done = 1'b0, prog_refused, write_locked_in, read_locked_in;
  logic [7:0]  prog_rdata, v;
  logic [31:0] checksum_in;
  logic [8:0]  lat_r = 9'd0;
  wire         link_clock_pin, link_data_in, link_data_out, link_data_oe;
  wire         prog_wr_req, prog_rd_req;
  wire  [7:0]  core_halt_ctrl, prog_enable_ctrl, prog_wdata;
  wire  [15:0] prog_addr;
  int          error_cnt, checks, cyc;

  twdrs_port #(.PART_ID(PID), .REV_ID(RID)) i_twdrs_port (.ref_clk(ref_clk), .nrst(nrst),
    .link_clock_pin(link_clock_pin), .link_data_in(link_data_in),
    .link_data_out(link_data_out), .link_data_oe(link_data_oe), .prog_done(prog_done),
    .prog_refused(prog_refused), .prog_rdata(prog_rdata), .write_locked_in(write_locked_in),
    .read_locked_in(read_locked_in), .checksum_in(checksum_in),
    .core_halt_ctrl(core_halt_ctrl), .prog_enable_ctrl(prog_enable_ctrl),
    .prog_addr(prog_addr), .prog_wdata(prog_wdata), .prog_wr_req(prog_wr_req),
    .prog_rd_req(prog_rd_req));
  twdrs_tool i_twdrs_tool (.ref_clk(ref_clk), .link_data_out(link_data_out),
    .link_data_oe(link_data_oe), .link_clock_pin(link_clock_pin),
    .link_data_in(link_data_in));

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // Memory responder completes each request after 300 cycles; timeout guard alongside.
  always @(posedge ref_clk) begin
    if (prog_wr_req === 1'b1 || prog_rd_req === 1'b1) lat_r <= 9'd300;
    else if (lat_r != 9'd0) lat_r <= lat_r - 9'd1;
    prog_done <= (lat_r == 9'd1);
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      error_cnt++;
      wrap_up();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic settle();
    repeat (6) @(negedge ref_clk);
  endtask
  task automatic sel(input logic [7:0] c);
    i_twdrs_tool.write(1'b1, c);
  endtask
  task automatic rd(input logic [7:0] c, output logic [7:0] r);
    sel(c);
    i_twdrs_tool.read(1'b0, r);
  endtask
  // Cleared outputs, identifier before any select, idle status.
  task automatic t_reset();
    @(negedge ref_clk);
    check({core_halt_ctrl, prog_enable_ctrl, prog_addr}, 32'h0);
    i_twdrs_tool.read(1'b0, v);
    check(v, PID);
    i_twdrs_tool.read(1'b1, v);
    check(v, 8'h00);
  endtask
  // Writable registers take a byte, read it back and show it at the ports.
  task automatic t_ctrl();
    logic [7:0] c [4] = '{8'h02, 8'hdf, 8'haf, 8'hae};
    logic [7:0] d [4] = '{8'ha5, 8'h3c, 8'h12, 8'h34};
    for (int i = 0; i < 4; i++) begin
      sel(c[i]);
      i_twdrs_tool.write(1'b0, d[i]);
      i_twdrs_tool.read(1'b0, v);
      check(v, d[i]);
    end
    settle();
    check({core_halt_ctrl, prog_enable_ctrl, prog_addr}, 32'ha53c1234);
  endtask
  // Read-only and unknown targets ignore writes and change nothing else.
  task automatic t_ro();
    logic [7:0] c [3] = '{8'h00, 8'h01, 8'h55};
    logic [7:0] e [3] = '{PID, RID, 8'h00};
    for (int i = 0; i < 3; i++) begin
      sel(c[i]);
      i_twdrs_tool.write(1'b0, 8'hff);
      i_twdrs_tool.read(1'b0, v);
      check(v, e[i]);
    end
    settle();
    check({core_halt_ctrl, prog_enable_ctrl, prog_addr}, 32'ha53c1234);
  endtask
  // Checksum bytes zero to three in ascending code order.
  task automatic t_chk();
    for (int i = 0; i < 4; i++) begin
      rd(8'ha9 + i[7:0], v);
      check(v, checksum_in[8*i +: 8]);
    end
  endtask
  // A read cut short keeps the pin driven until the low-clock abort, then the link recovers.
  task automatic t_cut();
    i_twdrs_tool.cut_low();
    check(link_data_oe, 1'b1);
    repeat (420) @(negedge ref_clk);
    check(link_data_oe, 1'b0);
    i_twdrs_tool.cut_end();
    i_twdrs_tool.read(1'b1, v);
    check(v, 8'h00);
  endtask
  // Refused write, busy status, access while busy, lock flags, read with prefetch.
  task automatic t_prog();
    @(posedge ref_clk);
    write_locked_in <= 1'b1;
    prog_refused <= 1'b1;
    sel(8'hbf);
    i_twdrs_tool.write(1'b0, 8'h3c);
    settle();
    check(prog_wdata, 8'h3c);
    i_twdrs_tool.read(1'b1, v);
    check(v, 8'h80);
    i_twdrs_tool.write(1'b0, 8'h77);
    settle();
    check(prog_wdata, 8'h3c);
    repeat (320) @(negedge ref_clk);
    i_twdrs_tool.read(1'b1, v);
    check(v, 8'h00);
    rd(8'hb7, v);
    check(v, 8'h81);
    @(posedge ref_clk);
    {write_locked_in, read_locked_in, prog_refused} <= 3'b010;
    rd(8'hbf, v);
    check(v, 8'h3c);
    repeat (320) @(negedge ref_clk);
    i_twdrs_tool.read(1'b0, v);
    check(v, 8'hc3);
    rd(8'hb7, v);
    check(v, 8'h40);
  endtask
  task automatic wrap_up();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Reset for six cycles, then the scenarios in turn.
  initial begin
    nrst = 1'b0;
    prog_refused = 1'b0;
    write_locked_in = 1'b0;
    read_locked_in = 1'b0;
    prog_rdata = 8'hc3;
    checksum_in = 32'h44332211;
    repeat (6) @(posedge ref_clk);
    nrst <= 1'b1;
    t_reset();
    t_ctrl();
    t_ro();
    t_chk();
    t_cut();
    t_prog();
    wrap_up();
  end
endmodule // tb_twdrs_port
